/* common/rtc_consts.svh */
// Timing counts, command codes and field positions of the single-wire seconds clock
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Clock period and cycle conversion (least times round up, longest round down)
`define RTC_CLK_NS 8
`define RTC_CYC_UP(ns) (((ns) + `RTC_CLK_NS - 1) / `RTC_CLK_NS)
`define RTC_CYC_DN(ns) ((ns) / `RTC_CLK_NS)

// Bus timing in ns
`define RTC_T_RSTL_NS 480000
`define RTC_T_PDH_NS 30000
`define RTC_T_PDL_NS 120000
`define RTC_T_SAMPLE_NS 30000
`define RTC_T_SEC_NS 1000000000

// Derived cycle counts
`define RTC_RSTL_CYC `RTC_CYC_UP(`RTC_T_RSTL_NS)
`define RTC_PDH_CYC `RTC_CYC_UP(`RTC_T_PDH_NS)
`define RTC_PDL_CYC `RTC_CYC_UP(`RTC_T_PDL_NS)
`define RTC_SAMPLE_CYC `RTC_CYC_UP(`RTC_T_SAMPLE_NS)
`define RTC_SEC_CYC `RTC_CYC_DN(`RTC_T_SEC_NS)

// Command codes
`define RTC_CMD_READ_ID 8'h33
`define RTC_CMD_MATCH_ID 8'h55
`define RTC_CMD_SKIP_ID 8'hcc
`define RTC_CMD_READ_CLK 8'h66
`define RTC_CMD_WRITE_CLK 8'h99

// Control byte fields and frame layout
`define RTC_CTL_OSC_LO 2
`define RTC_CTL_OSC_HI 3
`define RTC_CTL_USER_LSB 4
`define RTC_CTL_BITS 8
`define RTC_FRAME_BITS 40
`define RTC_ID_BITS 64
`define RTC_CRC_POLY 8'h8c

// Reset values
`define RTC_USER_RESET 4'h0
`define RTC_SEC_RESET 32'h0000_0000

`endif

/* common/rtc_pkg.sv */
// Types of the single-wire seconds clock
`default_nettype none
package rtc_pkg;
    typedef enum logic [6:0] {
        RTC_ST_IDLE   = 7'b000_0001,
        RTC_ST_IDCMD  = 7'b000_0010,
        RTC_ST_RDID   = 7'b000_0100,
        RTC_ST_MATCH  = 7'b000_1000,
        RTC_ST_FNCMD  = 7'b001_0000,
        RTC_ST_RDCLK  = 7'b010_0000,
        RTC_ST_WRCLK  = 7'b100_0000
    } rtc_state_t;
endpackage
`default_nettype wire

/* logic/rtc_single_wire.sv */
// Single-wire slave real-time clock with identity word and seconds counter
`default_nettype none
`include "rtc_consts.svh"

module rtc_single_wire
    import rtc_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
    parameter logic [47:0] SERIAL_NUM = 48'h0123_4567_89ab, // Arbitrary value
    parameter int unsigned RST_CYC = `RTC_RSTL_CYC,
    parameter int unsigned PDL_CYC = `RTC_PDL_CYC,
    parameter int unsigned PDH_CYC = `RTC_PDH_CYC,
    parameter int unsigned SAMPLE_CYC = `RTC_SAMPLE_CYC,
    parameter int unsigned SEC_CYC = `RTC_SEC_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic owire_in,
    output logic owire_out,
    output logic owire_oe,
    output logic osc_running,
    output logic [31:0] seconds_now
);
    localparam int CW = 32;
    // One LSB-first step of the check byte generator
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic b);
        crc8_step = {1'b0, crc[7:1]} ^ ((crc[0] ^ b) ? `RTC_CRC_POLY : 8'h00);
    endfunction

    // Check byte over the 56 leading identity bits
    function automatic logic [7:0] crc8_id(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
            c = crc8_step(c, d[i]);
        crc8_id = c;
    endfunction

    localparam logic [55:0] ID_BODY = {SERIAL_NUM, FAMILY_CODE};
    localparam logic [63:0] ID_WORD = {crc8_id(ID_BODY), ID_BODY};
    logic line_q;
    logic [CW-1:0] low_cnt_q;
    logic rst_seen_q;
    logic pwait_q;
    logic pdrive_q;
    logic [CW-1:0] pcnt_q;
    logic slot_q;
    logic [CW-1:0] slot_cnt_q;
    logic tx0_q;
    rtc_state_t state_q;
    logic [6:0] bcnt_q;
    logic [7:0] sh_q;
    logic mism_q;
    logic osc_q;
    logic [3:0] user_q;
    logic [31:0] buf_q;
    logic [31:0] cnt_q;
    logic pend_q;
    logic [CW-1:0] div_q;
    logic fall;
    logic rise;
    logic rst_ev;
    logic bit_ev;
    logic in_bit;
    logic [7:0] rx_byte;
    logic [7:0] ctl_rd;
    logic [39:0] frame;
    logic tx_mode;
    logic tx_bit;
    logic sec_tick;
    // Line edges and reset pulse recognition
    assign fall = line_q & ~owire_in;
    assign rise = ~line_q & owire_in;
    assign rst_ev = ~owire_in && low_cnt_q == CW'(RST_CYC - 1);
    assign bit_ev = slot_q && slot_cnt_q == CW'(SAMPLE_CYC - 1);
    assign in_bit = owire_in;
    assign rx_byte = {in_bit, sh_q[7:1]};
    // Control byte as read back
    assign ctl_rd = {user_q, osc_q, osc_q, 2'b00};
    assign frame = {buf_q, ctl_rd};
    assign tx_mode = (state_q == RTC_ST_RDID) || (state_q == RTC_ST_RDCLK);
    assign tx_bit = (state_q == RTC_ST_RDID) ? ID_WORD[bcnt_q[5:0]] : frame[6'(bcnt_q)];
    // Pin drive: open drain, only pulls low
    assign owire_out = 1'b0;
    assign owire_oe = tx0_q | pdrive_q;
    assign osc_running = osc_q;
    assign seconds_now = cnt_q;
    // Line sample and low-time counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_q <= 1'b1;
            low_cnt_q <= '0;
        end
        else
        begin
            line_q <= owire_in;
            if (owire_in)
                low_cnt_q <= '0;
            else if (low_cnt_q != CW'(RST_CYC - 1))
                low_cnt_q <= low_cnt_q + CW'(1);
        end
    end

    // Reset pulse and presence answer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_seen_q <= 1'b0;
            pwait_q <= 1'b0;
            pdrive_q <= 1'b0;
            pcnt_q <= '0;
        end
        else if (rst_ev)
        begin
            rst_seen_q <= 1'b1;
            pwait_q <= 1'b0;
            pdrive_q <= 1'b0;
        end
        else if (rst_seen_q && rise)
        begin
            rst_seen_q <= 1'b0;
            pwait_q <= 1'b1;
            pcnt_q <= '0;
        end
        else if (pwait_q)
        begin
            pcnt_q <= pcnt_q + CW'(1);
            if (pcnt_q == CW'(PDH_CYC - 1))
            begin
                pwait_q <= 1'b0;
                pdrive_q <= 1'b1;
                pcnt_q <= '0;
            end
        end
        else if (pdrive_q)
        begin
            pcnt_q <= pcnt_q + CW'(1);
            if (pcnt_q == CW'(PDL_CYC - 1))
                pdrive_q <= 1'b0;
        end
    end

    // Time slot tracker and zero-bit drive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_q <= 1'b0;
            slot_cnt_q <= '0;
            tx0_q <= 1'b0;
        end
        else if (rst_ev || rst_seen_q || pwait_q || pdrive_q)
        begin
            slot_q <= 1'b0;
            tx0_q <= 1'b0;
        end
        else if (fall && !slot_q)
        begin
            slot_q <= 1'b1;
            slot_cnt_q <= '0;
            tx0_q <= tx_mode && !tx_bit;
        end
        else if (bit_ev)
        begin
            slot_q <= 1'b0;
            tx0_q <= 1'b0;
        end
        else if (slot_q)
            slot_cnt_q <= slot_cnt_q + CW'(1);
    end

    // Command sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= RTC_ST_IDLE;
            bcnt_q <= '0;
            sh_q <= '0;
            mism_q <= 1'b0;
        end
        else if (rst_ev)
        begin
            state_q <= RTC_ST_IDCMD;
            bcnt_q <= '0;
            mism_q <= 1'b0;
        end
        else if (bit_ev)
        begin
            sh_q <= rx_byte;
            bcnt_q <= bcnt_q + 7'd1;
            case (state_q)
                RTC_ST_IDCMD:
                begin
                    if (bcnt_q == 7'd7)
                    begin
                        bcnt_q <= '0;
                        case (rx_byte)
                            `RTC_CMD_READ_ID: state_q <= RTC_ST_RDID;
                            `RTC_CMD_MATCH_ID: state_q <= RTC_ST_MATCH;
                            `RTC_CMD_SKIP_ID: state_q <= RTC_ST_FNCMD;
                            default: state_q <= RTC_ST_IDLE;
                        endcase
                    end
                end
                RTC_ST_RDID:
                begin
                    if (bcnt_q == 7'(`RTC_ID_BITS - 1))
                    begin
                        bcnt_q <= '0;
                        state_q <= RTC_ST_FNCMD;
                    end
                end
                RTC_ST_MATCH:
                begin
                    if (in_bit != ID_WORD[bcnt_q[5:0]])
                        mism_q <= 1'b1;
                    if (bcnt_q == 7'(`RTC_ID_BITS - 1))
                    begin
                        bcnt_q <= '0;
                        if (mism_q || in_bit != ID_WORD[63])
                            state_q <= RTC_ST_IDLE;
                        else
                            state_q <= RTC_ST_FNCMD;
                    end
                end
                RTC_ST_FNCMD:
                begin
                    if (bcnt_q == 7'd7)
                    begin
                        bcnt_q <= '0;
                        case (rx_byte)
                            `RTC_CMD_READ_CLK: state_q <= RTC_ST_RDCLK;
                            `RTC_CMD_WRITE_CLK: state_q <= RTC_ST_WRCLK;
                            default: state_q <= RTC_ST_IDLE;
                        endcase
                    end
                end
                RTC_ST_RDCLK:
                    if (bcnt_q == 7'(`RTC_FRAME_BITS - 1))
                        bcnt_q <= '0;
                RTC_ST_WRCLK:
                    if (bcnt_q == 7'(`RTC_FRAME_BITS - 1))
                        state_q <= RTC_ST_IDLE;
                default:
                    bcnt_q <= bcnt_q;
            endcase
        end
    end

    // Oscillator enable and user flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_q <= 1'b0;
            user_q <= `RTC_USER_RESET;
        end
        else if (bit_ev && state_q == RTC_ST_WRCLK && bcnt_q == 7'(`RTC_CTL_BITS - 1))
        begin
            osc_q <= rx_byte[`RTC_CTL_OSC_HI];
            user_q <= rx_byte[7:`RTC_CTL_USER_LSB];
        end
    end

    // Transfer buffer: snapshot on read command, filled on write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            buf_q <= `RTC_SEC_RESET;
        else if (bit_ev && state_q == RTC_ST_FNCMD && bcnt_q == 7'd7
                 && rx_byte == `RTC_CMD_READ_CLK)
            buf_q <= cnt_q;
        else if (bit_ev && state_q == RTC_ST_WRCLK && bcnt_q >= 7'(`RTC_CTL_BITS))
            buf_q[5'(bcnt_q - 7'(`RTC_CTL_BITS))] <= in_bit;
    end

    // Pending load of written counter bytes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_q <= 1'b0;
        else if (rst_ev)
            pend_q <= 1'b0;
        else if (bit_ev && state_q == RTC_ST_WRCLK
                 && bcnt_q == 7'(`RTC_FRAME_BITS - 1))
            pend_q <= 1'b1;
    end

    // One-second divider, runs only with the oscillator on
    assign sec_tick = osc_q && div_q == CW'(SEC_CYC - 1);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= '0;
        else if (!osc_q)
            div_q <= div_q;
        else if (sec_tick)
            div_q <= '0;
        else
            div_q <= div_q + CW'(1);
    end

    // Seconds counter: load at reset pulse wins over tick
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= `RTC_SEC_RESET;
        else if (rst_ev && pend_q)
            cnt_q <= buf_q;
        else if (sec_tick)
            cnt_q <= cnt_q + 32'd1;
    end

endmodule
`default_nettype wire

/* sim/rtc_chk_sva.sv */
// Port checks of the single-wire seconds clock
`default_nettype none
module rtc_chk
#(
    parameter int unsigned RST_CYC = 200,
    parameter int unsigned PDL_CYC = 50,
    parameter int unsigned PDH_CYC = 30,
    parameter int unsigned SAMPLE_CYC = 30,
    parameter int unsigned SEC_CYC = 100
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic owire_in,
    input wire logic owire_oe,
    input wire logic osc_running,
    input wire logic [31:0] seconds_now
);
    // Time after a reset pulse by which the presence pulse is surely over
    localparam int PRW = PDH_CYC + PDL_CYC + 20;
    logic [15:0] low_q, fall_q, hi_q, since_q;
    // Run lengths: line low, since a fall, drive high, since a reset pulse
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            low_q <= 16'h0;
            fall_q <= 16'hffff;
            hi_q <= 16'h0;
            since_q <= 16'hffff;
        end
        else
        begin
            low_q <= owire_in ? 16'h0 : low_q + 16'(low_q != 16'hffff);
            fall_q <= (!owire_in && low_q == 16'h0) ? 16'h0 : fall_q + 16'(fall_q != 16'hffff);
            hi_q <= owire_oe ? hi_q + 16'(hi_q != 16'hffff) : 16'h0;
            since_q <= (owire_in && low_q >= RST_CYC) ? 16'h0 : since_q + 16'(since_q != 16'hffff);
        end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    hold_stopped_a: assert property (!osc_running && owire_in |=> $stable(seconds_now))
        else $error("count moved while stopped");
    step_one_a: assert property (owire_in |=> (seconds_now == $past(seconds_now)) ||
        (seconds_now == $past(seconds_now) + 32'h1)) else $error("count step not one");
    wrap_zero_a: assert property (owire_in && seconds_now == 32'hffff_ffff |=>
        seconds_now inside {32'hffff_ffff, 32'h0}) else $error("bad wrap");
    load_reset_a: assert property ((seconds_now != $past(seconds_now)) &&
        (seconds_now != $past(seconds_now) + 32'h1) |-> $past(low_q) >= RST_CYC - 2)
        else $error("count loaded outside reset pulse");
    osc_slot_a: assert property ($changed(osc_running) |->
        fall_q inside {[SAMPLE_CYC - 2:SAMPLE_CYC + 2]})
        else $error("oscillator changed outside a sample");
    bit_drive_a: assert property ($fell(owire_oe) && since_q > PRW |->
        hi_q inside {[SAMPLE_CYC - 2:SAMPLE_CYC + 2]})
        else $error("zero bit drive length");
    drive_start_a: assert property ($rose(owire_oe) && since_q > PRW |-> fall_q <= 16'd2)
        else $error("drive outside a master slot");
    pres_quiet_a: assert property (since_q < 16'(PDH_CYC - 2) |-> !owire_oe)
        else $error("drive during presence wait");
endmodule
bind rtc_single_wire rtc_chk #(.RST_CYC(RST_CYC), .PDL_CYC(PDL_CYC), .PDH_CYC(PDH_CYC),
    .SAMPLE_CYC(SAMPLE_CYC), .SEC_CYC(SEC_CYC))
    i_chk (.clk(clk), .rst_n(rst_n), .owire_in(owire_in), .owire_oe(owire_oe),
    .osc_running(osc_running), .seconds_now(seconds_now));
`default_nettype wire

/* sim/rtc_mst.sv */
// Bus master model pulling the shared line low
`default_nettype none
module rtc_mst
#(
    parameter int SMP = 3750,
    parameter int WAIT_CYC = 4000
)
(
    input wire logic clk,
    input wire logic line,
    output logic drv_low
);
    timeunit 1ns;
    timeprecision 100ps;
    initial drv_low = 1'b0;
    // Move n cycles, landing just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk) #1;
    endtask
    // Reset pulse, then count presence cycles
    task automatic bus_reset(input int low_cyc, output int pres);
        pres = 0;
        drv_low = 1'b1;
        step(low_cyc);
        drv_low = 1'b0;
        repeat (WAIT_CYC)
        begin
            step(1);
            pres += !line;
        end
    endtask
    // Write slot; a one is a short low, a zero holds past the sample point
    task automatic wr_bit(input logic b);
        drv_low = 1'b1;
        step(b ? 2 : SMP + 10);
        drv_low = 1'b0;
        step(b ? SMP + 20 : 12);
    endtask
    task automatic wr_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) wr_bit(v[i]);
    endtask
    // Read slot sampled well before the device lets go
    task automatic rd_bit(output logic b);
        drv_low = 1'b1;
        step(2);
        drv_low = 1'b0;
        step(SMP / 2);
        b = line;
        step(SMP - SMP / 2 + 20);
    endtask
    task automatic rd_byte(output logic [7:0] v);
        for (int i = 0; i < 8; i++) rd_bit(v[i]);
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Testbench of the single-wire seconds clock
`default_nettype none
`include "rtc_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Bus timing scaled down so that a full run stays short
    localparam int unsigned RST_CYC = 60;
    localparam int unsigned PDL_CYC = 20;
    localparam int unsigned PDH_CYC = 20;
    localparam int unsigned SAMPLE_CYC = 20;
    localparam int unsigned SEC_CYC = 500;
    localparam logic [7:0] FAM = 8'h3c; // Arbitrary value
    localparam logic [47:0] SER = 48'h9e37_1c55_a0f2; // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic drv_low, owire_out, owire_oe, osc_running;
    logic [31:0] seconds_now, cnt;
    logic [7:0] b;
    logic [63:0] id;
    wire line = !(drv_low | owire_oe);
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int pres;
    always #4 clk = ~clk;
    rtc_single_wire #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .RST_CYC(RST_CYC),
        .PDL_CYC(PDL_CYC), .PDH_CYC(PDH_CYC), .SAMPLE_CYC(SAMPLE_CYC), .SEC_CYC(SEC_CYC))
        i_dut (.clk(clk), .rst_n(rst_n),
        .owire_in(line), .owire_out(owire_out), .owire_oe(owire_oe),
        .osc_running(osc_running), .seconds_now(seconds_now));
    rtc_mst #(.SMP(SAMPLE_CYC), .WAIT_CYC(PDH_CYC + PDL_CYC + 20))
        i_mst (.clk(clk), .line(line), .drv_low(drv_low));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, about twice the length of a clean run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    // Reflected check byte over family and serial
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
            c = (c >> 1) ^ (((c[0] ^ d[i]) != 1'b0) ? `RTC_CRC_POLY : 8'h00);
        return c;
    endfunction
    task automatic t_reset();
        i_mst.bus_reset(RST_CYC + 20, pres);
        chk(pres, PDL_CYC);
    endtask
    // Identity read, then control and count write
    task automatic t_ident_write();
        t_reset();
        i_mst.wr_byte(`RTC_CMD_READ_ID);
        for (int i = 0; i < 8; i++)
        begin
            i_mst.rd_byte(b);
            id[i*8 +: 8] = b;
        end
        chk(id, {crc8({SER, FAM}), SER, FAM});
        chk({osc_running, seconds_now}, 33'h0);
        i_mst.wr_byte(`RTC_CMD_WRITE_CLK);
        i_mst.wr_byte(8'h58);
        chk(osc_running, 1'b1);
        for (int i = 0; i < 4; i++) i_mst.wr_byte(8'hff);
        chk(seconds_now[31:8], 24'h0);
    endtask
    // Reset pulse loads all ones; read shows control, wrapped count, repeat
    task automatic t_read();
        t_reset();
        i_mst.wr_byte(`RTC_CMD_SKIP_ID);
        i_mst.wr_byte(`RTC_CMD_READ_CLK);
        i_mst.rd_byte(b);
        chk(b, 8'h5c);
        for (int i = 0; i < 4; i++)
        begin
            i_mst.rd_byte(b);
            cnt[i*8 +: 8] = b;
        end
        chk(cnt <= 32'h1, 1'b1);
        i_mst.rd_byte(b);
        chk(b, 8'h5c);
    endtask
    // Clock command with no identity step is ignored
    task automatic t_unsel();
        t_reset();
        i_mst.wr_byte(`RTC_CMD_READ_CLK);
        i_mst.rd_byte(b);
        chk(b, 8'hff);
        chk(owire_out, 1'b0);
    endtask
    // Match with a flipped top or bottom bit is ignored, the exact identity is served
    task automatic t_match();
        logic [63:0] want;
        logic [63:0] flip;
        want = {crc8({SER, FAM}), SER, FAM};
        for (int k = 0; k < 3; k++)
        begin
            flip = (k == 0) ? 64'h8000_0000_0000_0000 : ((k == 1) ? 64'h1 : 64'h0);
            t_reset();
            i_mst.wr_byte(`RTC_CMD_MATCH_ID);
            for (int i = 0; i < 8; i++) i_mst.wr_byte(8'((want ^ flip) >> (i * 8)));
            i_mst.wr_byte(`RTC_CMD_READ_CLK);
            i_mst.rd_byte(b);
            chk(b, (k == 2) ? 8'h5c : 8'hff);
        end
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        t_ident_write();
        t_read();
        t_match();
        t_unsel();
        wrap_up();
    end
endmodule
`default_nettype wire
